// file: logic/rcr_pkg.sv
// Operation
// - Each kernel clock cycle outside freeze and deep halt copies live counters to shadows and sets sync flag.
// - Reading subsecond low byte freezes all shadow bytes until date third byte read.
// - Reading time first byte also starts the freeze until date third byte read.
// - System reset restores shadows; software waits for sync flag before reading.
// - With shadow bypass set, calendar reads return live counter values.
// - No shadow updates during deep halt mode.
// - With shadow bypass, calendar reads take one extra system clock cycle.
// - Every system reset restores shadow and status registers to defaults.
// - Only power-on reset restores counters, control, prescaler and similar registers.
// - Once enabled, the clock keeps counting through non power-on resets.
// - Power-on reset stops the clock and sets all registers to reset values.
// - Subsecond registers return the synchronous prescaler counter.
// - A shift adds the 15-bit fraction field to the 16-bit prescaler counter.
// - Add-one-second in the same shift also adds a whole second.
// - Writing shift low byte starts shift, sets pending; hardware clears on completion.
// - Shadow bypass resets to zero.
package rcr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SS_LO  = 8'h00;
    localparam logic [7:0] OFS_SS_HI  = 8'h04;
    localparam logic [7:0] OFS_TIME1  = 8'h08;
    localparam logic [7:0] OFS_TIME2  = 8'h0C;
    localparam logic [7:0] OFS_TIME3  = 8'h10;
    localparam logic [7:0] OFS_DATE1  = 8'h14;
    localparam logic [7:0] OFS_DATE2  = 8'h18;
    localparam logic [7:0] OFS_DATE3  = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_CTRL   = 8'h24;
    localparam logic [7:0] OFS_SHF_HI = 8'h28;
    localparam logic [7:0] OFS_SHF_LO = 8'h2C;
    localparam logic [7:0] OFS_SDIV   = 8'h30;
    localparam logic [7:0] OFS_ADIV   = 8'h34;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int          STS_SYNC_BIT  = 0;
    localparam int          STS_PEND_BIT  = 1;
    localparam int          CTL_BYP_BIT   = 0;
    localparam int          SHH_PLUS1_BIT = 7;
    localparam logic [14:0] SDIV_RST      = 15'h00FF;
    localparam logic [6:0]  ADIV_RST      = 7'h7F;
    localparam logic [16:0] SEC_LAST      = 17'h1_517F;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_DATA = 2'b01,
        RD_RESP = 2'b11,
        RD_WAIT = 2'b10
    } rcr_rd_type;

    typedef struct packed {
        logic [15:0] ss;
        logic [16:0] sec;
        logic [23:0] day;
    } rcr_cal_type;

    typedef struct packed {
        logic [2:0]  ksync;
        logic [1:0]  ensync;
        logic [1:0]  hsync;
        rcr_cal_type cal;
        logic [6:0]  acnt;
        logic [14:0] sdiv;
        logic [6:0]  adiv;
        logic        bypass;
        rcr_cal_type sh;
        logic        sync_flag;
        logic        freeze;
        logic        shift_pending_flag;
        logic        add_one_second;
        logic [14:0] fraction_shift_field;
        logic        aw_have;
        logic [7:0]  awaddr;
        logic        awready;
        logic        w_have;
        logic [31:0] wdata;
        logic        wstrb0;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        rcr_rd_type  rst;
        logic [7:0]  raddr;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rcr_state_type;
endpackage : rcr_pkg

// file: logic/rcr_top.sv
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module rcr_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        por_n,
    input  wire logic        rtc_kernel_clock,
    input  wire logic        rtc_clock_enable,
    input  wire logic        deep_halt,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);
    rcr_pkg::rcr_state_type s_q;
    rcr_pkg::rcr_state_type s_d;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] cal_byte(input rcr_pkg::rcr_cal_type c,
                                            input logic [7:0] a);
        case (a)
            rcr_pkg::OFS_SS_LO: cal_byte = c.ss[7:0];
            rcr_pkg::OFS_SS_HI: cal_byte = c.ss[15:8];
            rcr_pkg::OFS_TIME1: cal_byte = c.sec[7:0];
            rcr_pkg::OFS_TIME2: cal_byte = c.sec[15:8];
            rcr_pkg::OFS_TIME3: cal_byte = {7'h00, c.sec[16]};
            rcr_pkg::OFS_DATE1: cal_byte = c.day[7:0];
            rcr_pkg::OFS_DATE2: cal_byte = c.day[15:8];
            rcr_pkg::OFS_DATE3: cal_byte = c.day[23:16];
            default:            cal_byte = 8'h00;
        endcase
    endfunction : cal_byte

    function automatic logic is_cal(input logic [7:0] a);
        is_cal = ({a[7:2], 2'b00} <= rcr_pkg::OFS_DATE3);
    endfunction : is_cal

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic       tick;
        logic       run;
        logic       sec_inc;
        logic       wr_go;
        logic [7:0] wa;
        logic [7:0] ra;
        tick    = 1'b0;
        run     = 1'b0;
        sec_inc = 1'b0;
        wr_go   = 1'b0;
        wa      = 8'h00;
        ra      = 8'h00;
        s_d     = s_q;

        // Kernel clock, enable and halt arrive from outside this domain
        s_d.ksync  = {s_q.ksync[1:0], rtc_kernel_clock};
        s_d.ensync = {s_q.ensync[0], rtc_clock_enable};
        s_d.hsync  = {s_q.hsync[0], deep_halt};
        // Edge seen late by two cycles; fine since sysclk >= 4x kernel
        tick = s_q.ksync[1] & ~s_q.ksync[2];
        run  = tick & s_q.ensync[1];

        // Live calendar counters
        if (run) begin
            if (s_q.shift_pending_flag) begin
                s_d.cal.ss = s_q.cal.ss + {1'b0, s_q.fraction_shift_field};
                sec_inc    = s_q.add_one_second;
                s_d.shift_pending_flag = 1'b0;
            end else if (s_q.acnt == 7'h00) begin
                s_d.acnt = s_q.adiv;
                if (s_q.cal.ss == 16'h0000) begin
                    s_d.cal.ss = {1'b0, s_q.sdiv};
                    sec_inc    = 1'b1;
                end else begin
                    s_d.cal.ss = s_q.cal.ss - 16'h0001;
                end
            end else begin
                s_d.acnt = s_q.acnt - 7'h01;
            end
        end
        if (sec_inc) begin
            if (s_q.cal.sec == rcr_pkg::SEC_LAST) begin
                s_d.cal.sec = 17'h0_0000;
                s_d.cal.day = s_q.cal.day + 24'h00_0001;
            end else begin
                s_d.cal.sec = s_q.cal.sec + 17'h0_0001;
            end
        end

        // Write channel
        if (s_q.awready && awvalid) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr  = awaddr;
        end
        if (s_q.wready && wvalid) begin
            s_d.w_have = 1'b1;
            s_d.wdata  = wdata;
            s_d.wstrb0 = wstrb[0];
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        wr_go = s_q.aw_have & s_q.w_have & ~s_q.bvalid;
        wa    = {s_q.awaddr[7:2], 2'b00};
        if (wr_go) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = rcr_pkg::RESP_OKAY;
            if (is_cal(wa) || wa > rcr_pkg::OFS_ADIV) begin
                s_d.bresp = rcr_pkg::RESP_SLVERR;
            end else if (s_q.wstrb0) begin
                case (wa)
                    rcr_pkg::OFS_STATUS: begin
                        if (!s_q.wdata[rcr_pkg::STS_SYNC_BIT]) begin
                            s_d.sync_flag = 1'b0;
                        end
                    end
                    rcr_pkg::OFS_CTRL: begin
                        s_d.bypass = s_q.wdata[rcr_pkg::CTL_BYP_BIT];
                    end
                    rcr_pkg::OFS_SHF_HI: begin
                        // Shift fields locked while a shift is pending
                        if (!s_q.shift_pending_flag) begin
                            s_d.add_one_second = s_q.wdata[rcr_pkg::SHH_PLUS1_BIT];
                            s_d.fraction_shift_field[14:8] = s_q.wdata[6:0];
                        end
                    end
                    rcr_pkg::OFS_SHF_LO: begin
                        if (!s_q.shift_pending_flag) begin
                            s_d.fraction_shift_field[7:0] = s_q.wdata[7:0];
                            s_d.shift_pending_flag        = 1'b1;
                        end
                    end
                    rcr_pkg::OFS_SDIV: s_d.sdiv = s_q.wdata[14:0];
                    rcr_pkg::OFS_ADIV: s_d.adiv = s_q.wdata[6:0];
                    default: ;
                endcase
            end
        end

        // Read channel
        ra = {s_q.raddr[7:2], 2'b00};
        case (s_q.rst)
            rcr_pkg::RD_IDLE: begin
                if (s_q.arready && arvalid) begin
                    s_d.raddr = araddr;
                    if (s_q.bypass && is_cal(araddr)) begin
                        s_d.rst = rcr_pkg::RD_WAIT;
                    end else begin
                        s_d.rst = rcr_pkg::RD_DATA;
                    end
                end
            end
            rcr_pkg::RD_WAIT: begin
                s_d.rst = rcr_pkg::RD_DATA;
            end
            rcr_pkg::RD_DATA: begin
                s_d.rvalid = 1'b1;
                s_d.rst    = rcr_pkg::RD_RESP;
                s_d.rresp  = rcr_pkg::RESP_OKAY;
                s_d.rdata  = 32'h0000_0000;
                if (is_cal(ra)) begin
                    if (s_q.bypass) begin
                        s_d.rdata[7:0] = cal_byte(s_q.cal, ra);
                    end else begin
                        s_d.rdata[7:0] = cal_byte(s_q.sh, ra);
                    end
                    if (ra == rcr_pkg::OFS_SS_LO) begin
                        s_d.freeze = 1'b1;
                    end
                    if (ra == rcr_pkg::OFS_TIME1) begin
                        s_d.freeze = 1'b1;
                    end
                    if (ra == rcr_pkg::OFS_DATE3) begin
                        s_d.freeze = 1'b0;
                    end
                end else begin
                    case (ra)
                        rcr_pkg::OFS_STATUS: begin
                            s_d.rdata[rcr_pkg::STS_SYNC_BIT] = s_q.sync_flag;
                            s_d.rdata[rcr_pkg::STS_PEND_BIT] = s_q.shift_pending_flag;
                        end
                        rcr_pkg::OFS_CTRL: s_d.rdata[rcr_pkg::CTL_BYP_BIT] = s_q.bypass;
                        rcr_pkg::OFS_SHF_HI: begin
                            s_d.rdata[7:0] = {s_q.add_one_second,
                                              s_q.fraction_shift_field[14:8]};
                        end
                        rcr_pkg::OFS_SHF_LO: s_d.rdata[7:0] = s_q.fraction_shift_field[7:0];
                        rcr_pkg::OFS_SDIV:   s_d.rdata[14:0] = s_q.sdiv;
                        rcr_pkg::OFS_ADIV:   s_d.rdata[6:0] = s_q.adiv;
                        default:             s_d.rresp = rcr_pkg::RESP_SLVERR;
                    endcase
                end
            end
            rcr_pkg::RD_RESP: begin
                if (rready) begin
                    s_d.rvalid = 1'b0;
                    s_d.rst    = rcr_pkg::RD_IDLE;
                end
            end
            default: s_d.rst = rcr_pkg::RD_IDLE;
        endcase

        // Shadow copy; set placed after software clear so the set wins
        // Next freeze used: a copy in the cycle of the opening read would tear the sequence
        if (tick && !s_d.freeze && !s_q.hsync[1]) begin
            s_d.sh        = s_d.cal;
            s_d.sync_flag = 1'b1;
        end

        s_d.awready = ~s_d.aw_have & ~s_d.bvalid;
        s_d.wready  = ~s_d.w_have & ~s_d.bvalid;
        s_d.arready = (s_d.rst == rcr_pkg::RD_IDLE);

        // System reset: counters keep running, shadows and status cleared
        if (!aresetn) begin
            s_d.sh        = '0;
            s_d.sync_flag = 1'b0;
            s_d.freeze    = 1'b0;
            s_d.shift_pending_flag = 1'b0;
            s_d.aw_have   = 1'b0;
            s_d.w_have    = 1'b0;
            s_d.awready   = 1'b0;
            s_d.wready    = 1'b0;
            s_d.bvalid    = 1'b0;
            s_d.bresp     = rcr_pkg::RESP_OKAY;
            s_d.arready   = 1'b0;
            s_d.rst       = rcr_pkg::RD_IDLE;
            s_d.rvalid    = 1'b0;
            s_d.rdata     = 32'h0000_0000;
            s_d.rresp     = rcr_pkg::RESP_OKAY;
        end
        // Power-on reset holds the clock stopped with everything cleared except the prescalers, which load SDIV_RST and ADIV_RST
        if (!por_n) begin
            s_d        = '0;
            s_d.sdiv   = rcr_pkg::SDIV_RST;
            s_d.adiv   = rcr_pkg::ADIV_RST;
        end
    end

    always_ff @(posedge aclk) begin
        s_q <= s_d;
    end

    assign awready = s_q.awready;
    assign wready  = s_q.wready;
    assign bvalid  = s_q.bvalid;
    assign bresp   = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid  = s_q.rvalid;
    assign rdata   = s_q.rdata;
    assign rresp   = s_q.rresp;
endmodule : rcr_top

// file: bench/rcr_top_properties.sv
`timescale 1ns/1ps
module rcr_top_properties (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        por_n,
    input wire logic [7:0]  awaddr,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [7:0]  araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready
);
    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !por_n);
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped before handshake");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
        else $error("read answer changed before handshake");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write answer late");
    a_read_answer: assert property (arvalid && arready |-> ##[2:3] rvalid)
        else $error("read answer late");
    a_read_blocked: assert property (rvalid |-> !arready)
        else $error("read accepted while answer pending");
    a_write_blocked: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while answer pending");
    a_bad_addr: assert property (arvalid && arready && araddr > 8'h34 |->
        ##[2:3] rvalid && rresp == rcr_pkg::RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");
    a_cal_write: assert property (awvalid && awready && wvalid && wready && awaddr <= 8'h1C
        |-> ##[1:2] bvalid && bresp == rcr_pkg::RESP_SLVERR)
        else $error("calendar write not refused");
endmodule : rcr_top_properties

bind rcr_top rcr_top_properties i_props (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

// file: bench/test_rtc_calendar_read_and_shift.sv
`timescale 1ns/1ps
module test_rtc_calendar_read_and_shift;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        por_n = 1'b0;
    logic        kclk = 1'b0;
    logic        ken = 1'b0;
    logic        halt = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        wvalid = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready = 1'b0;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready = 1'b0;
    logic [31:0] d;
    logic [1:0]  r;
    int          lat;
    int          nlat;
    int          errors = 0;
    int          checks_done = 0;
    int          cycles = 0;

    rcr_top i_dut (.aclk(aclk), .aresetn(aresetn), .por_n(por_n), .rtc_kernel_clock(kclk),
        .rtc_clock_enable(ken), .deep_halt(halt), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    always #4 aclk = ~aclk;

    // Kernel clock at a tenth of the allowed rate, so a poll always beats the next tick
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        kclk <= (cycles % 40) >= 20;
        if (cycles == 20000) begin
            errors = errors + 1;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        lat = 0;
        @(posedge aclk);
        while (!arready) @(posedge aclk);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            lat++;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    task rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
        rd(a);
        chk(d & m, e);
    endtask : rc

    task wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_done;
        logic w_done;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awready && !aw_done) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_done) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        // Ready held from the request until the answer is sampled
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task ticks(input int n);
        repeat (n * 40) @(posedge aclk);
    endtask : ticks

    task defaults;
        rc(8'h24, 32'h0);
        rc(8'h30, 32'h00FF);
        rc(8'h34, 32'h007F);
    endtask : defaults

    task do_shift(input logic [7:0] hi, input logic [7:0] lo);
        rc(8'h04, 32'h0, 32'h80);
        wr(8'h28, {24'h0, hi});
        wr(8'h2C, {24'h0, lo});
        rc(8'h20, 32'h2, 32'h2);
        ken <= 1'b1;
        do rd(8'h20); while (d[1] !== 1'b0);
        ken <= 1'b0;
    endtask : do_shift

    task sync_wait;
        wr(8'h20, 32'h0);
        ticks(2);
        rc(8'h20, 32'h1, 32'h1);
    endtask : sync_wait

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        defaults();
        rd(8'h38);
        chk(d, 32'h0);
        chk(32'(r), 32'(rcr_pkg::RESP_SLVERR));
        wr(8'h00, 32'h1);
        chk(32'(r), 32'(rcr_pkg::RESP_SLVERR));
        sync_wait();
        rc(8'h00, 32'h0);
        rc(8'h1C, 32'h0);
        $display("test defaults done");
        do_shift(8'h80, 8'h05);
        sync_wait();
        rc(8'h00, 32'h05);
        rc(8'h08, 32'h01);
        rc(8'h1C, 32'h0);
        do_shift(8'h01, 8'h02);
        sync_wait();
        rc(8'h00, 32'h07);
        rc(8'h04, 32'h01);
        rc(8'h08, 32'h01);
        rc(8'h1C, 32'h0);
        $display("test shift done");
        for (int i = 0; i < 2; i++) begin
            rd(8'(i * 8));
            wr(8'h20, 32'h0);
            ticks(3);
            rc(8'h20, 32'h0, 32'h1);
            rd(8'h1C);
            ticks(2);
            rc(8'h20, 32'h1, 32'h1);
        end
        halt <= 1'b1;
        wr(8'h20, 32'h0);
        ticks(3);
        rc(8'h20, 32'h0, 32'h1);
        $display("test freeze done");
        wr(8'h24, 32'h1);
        rc(8'h24, 32'h1);
        nlat = lat;
        do_shift(8'h00, 8'h10);
        rd(8'h00);
        chk(d, 32'h17);
        chk(32'(lat), 32'(nlat + 1));
        rc(8'h00, 32'h17);
        rc(8'h1C, 32'h0);
        wr(8'h24, 32'h0);
        rc(8'h00, 32'h07);
        rc(8'h1C, 32'h0);
        $display("test bypass done");
        wr(8'h24, 32'h1);
        wr(8'h30, 32'h1234);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc(8'h24, 32'h1);
        rc(8'h30, 32'h1234);
        rc(8'h00, 32'h17);
        rc(8'h1C, 32'h0);
        wr(8'h24, 32'h0);
        rc(8'h00, 32'h0);
        rc(8'h1C, 32'h0);
        rc(8'h20, 32'h0, 32'h3);
        halt <= 1'b0;
        wr(8'h20, 32'h0);
        ticks(2);
        rc(8'h20, 32'h1, 32'h1);
        $display("test system reset done");
        por_n <= 1'b0;
        repeat (2) @(posedge aclk);
        por_n <= 1'b1;
        defaults();
        wr(8'h24, 32'h1);
        rc(8'h00, 32'h0);
        $display("test power-on reset done");
        close_out();
    end
endmodule : test_rtc_calendar_read_and_shift
